// ===== src/event_timer_defines.vh
`ifndef EVENT_TIMER_DEFINES_VH
`define EVENT_TIMER_DEFINES_VH

// Register byte offsets inside the 4 KB decode window
`define ET_OFS_CFG       12'h000
`define ET_OFS_CNT_LO    12'h008
`define ET_OFS_CNT_HI    12'h00C
`define ET_OFS_INT_STS   12'h010
`define ET_OFS_INT_MASK  12'h014
`define ET_OFS_OFFLOAD   12'h018
`define ET_OFS_CALIB     12'h01C
// Timer n block at TMR_BASE + n * TMR_STRIDE
`define ET_TMR_PAGE      4'h1
`define ET_TMR_CFG       3'h0
`define ET_TMR_CMP_LO    3'h1
`define ET_TMR_CMP_HI    3'h2
`define ET_TMR_PER_LO    3'h3
`define ET_TMR_PER_HI    3'h4

// Field positions
`define ET_CFG_CNT_EN    0
`define ET_TCFG_EN       0
`define ET_TCFG_PERIODIC 1
`define ET_OFL_SLOW      0
`define ET_OFL_BLOCKED   1
`define ET_OFL_REQ       2

// Sizes and reset values
`define ET_NUM_TMR       8
`define ET_FRAC_W        18
`define ET_SLOW_W        82
`define ET_CAL_W         28
`define ET_PERIODIC_CAP  8'h01
`define ET_RST_CFG       1'b0
`define ET_RST_MASK      8'h00
`define ET_RST_CNT       64'h0000_0000_0000_0000

// Timing: longest tick time and the fast tick rate
`define ET_TICK_MAX_NS   100
`define ET_FAST_HZ       24000000

`endif

// ===== src/timer_cmp.v
`timescale 1ns/100ps
`include "event_timer_defines.vh"

module timer_cmp #(
  parameter HAS_PERIOD = 0
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [63:0] cnt_i,
  input  wire        step_i,
  input  wire        en_i,
  input  wire        periodic_i,
  input  wire [31:0] wdat_i,
  input  wire [3:0]  wr_i,
  output wire [63:0] cmp_o,
  output wire [63:0] per_o,
  output reg         fire_o
);

  reg  [63:0] cmp_ff;
  reg  [63:0] per_ff;
  wire        hit;

  // Fire once per new count value, not while the count stands still
  assign hit   = en_i & step_i & (cnt_i == cmp_ff);
  assign cmp_o = cmp_ff;
  assign per_o = per_ff;

  // Comparator and period storage; a bus write beats auto-advance
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_ff <= 64'hFFFF_FFFF_FFFF_FFFF;
      per_ff <= 64'h0000_0000_0000_0000;
      fire_o <= 1'b0;
    end else begin
      fire_o <= hit;
      if (wr_i[0]) begin
        cmp_ff[31:0] <= wdat_i;
      end else if (wr_i[1]) begin
        cmp_ff[63:32] <= wdat_i;
      end else if (hit && periodic_i && (HAS_PERIOD != 0)) begin
        cmp_ff <= cmp_ff + per_ff;
      end
      if (HAS_PERIOD != 0 && wr_i[2]) begin
        per_ff[31:0] <= wdat_i;
      end
      if (HAS_PERIOD != 0 && wr_i[3]) begin
        per_ff[63:32] <= wdat_i;
      end
    end
  end

endmodule

// ===== src/event_timer.v
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`include "event_timer_defines.vh"

// Behaviour
// - Eight independent timers, each with its own interrupt output.
// - One shared main counter; each timer owns comparator and value register.
// - Timer interrupts when main counter equals its value register.
// - Timer 0 also supports periodic interrupts.
// - Counter only moves upward; consecutive reads never repeat unless wrapped; here reads between count steps return the same value.
// - Counter advances by one per 24 MHz tick while counting enabled.
// - Within 100 us, time off by at most two ticks; tick at most 100 ns.
// - With fast clock stopped, counting continues from the 32.768 KHz clock.
// - Offload to slow clock refused while any comparator is active.
// - Slow counting adds a 28-bit calibration value from the power controller.
// - Offload adds below 10 ppb error given boot calibration.
// - Entry loads count into upper 64 of 82-bit slow counter, then adds calibration.
// - Mode switches only on slow clock rising edge, seen via two-flop synchroniser.
// - Exit reloads fast count from upper 64 bits, keeps 18 fraction bits.
module event_timer (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [31:0] adr_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  input  wire        we_i,
  input  wire [3:0]  sel_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  output reg         ack_o,
  input  wire [19:0] decode_base_i,
  input  wire        tick_fast_i,
  input  wire        rtc_clk_i,
  input  wire        offload_req_i,
  input  wire [27:0] calib_i,
  output wire        slow_mode_o,
  output reg  [7:0]  timer_irq_o,
  output reg         irq_o
);

  localparam ST_FAST = 2'd0;
  localparam ST_PARK = 2'd1;
  localparam ST_SLOW = 2'd2;

  // Tick period in ns must stay within the longest tick time
  localparam TICK_NS = 1000000000 / `ET_FAST_HZ;

  reg  [63:0]               cnt_ff;
  reg  [63:0]               nxt_cnt;
  reg  [`ET_SLOW_W-1:0]     slow_ff;
  reg  [`ET_SLOW_W-1:0]     nxt_slow;
  reg  [1:0]                state_ff;
  reg  [1:0]                nxt_state;
  reg                       cnt_en_ff;
  reg  [7:0]                tmr_en_ff;
  reg  [7:0]                tmr_per_ff;
  reg  [7:0]                sts_ff;
  reg  [7:0]                mask_ff;
  reg  [63:0]               view_prev_ff;
  reg                       rtc_s1_ff;
  reg                       rtc_s2_ff;
  reg                       rtc_s3_ff;
  reg  [31:0]               rd_val;
  wire [63:0]               view;
  wire                      rtc_rise;
  wire                      any_active;
  wire                      req_hit;
  wire                      wr_go;
  wire [11:0]               ofs;
  wire [2:0]                tsel;
  wire [2:0]                treg;
  wire                      tpage;
  wire [31:0]               bmask;
  wire [7:0]                fire;
  wire [63:0]               cmp_w [0:7];
  wire [63:0]               per_w [0:7];
  wire [`ET_SLOW_W-1:0]     cal_ext;
  wire [7:0]                per_cap;

  // Merge write data under byte enables
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] m;
    begin
      merge = (old_v & ~m) | (new_v & m);
    end
  endfunction

  assign req_hit = cyc_i & stb_i & (adr_i[31:12] == decode_base_i);
  assign wr_go   = req_hit & we_i & ~ack_o;
  assign ofs     = adr_i[11:0];
  assign tpage   = (ofs[11:8] == `ET_TMR_PAGE);
  assign tsel    = ofs[7:5];
  assign treg    = ofs[4:2];
  assign bmask   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  assign any_active  = |tmr_en_ff;
  assign slow_mode_o = (state_ff != ST_FAST);
  assign cal_ext     = {{(`ET_SLOW_W-`ET_CAL_W){1'b0}}, calib_i};
  assign per_cap     = `ET_PERIODIC_CAP;

  // visible time never steps back across a mode switch
  assign view = (state_ff == ST_FAST) ? cnt_ff : slow_ff[`ET_SLOW_W-1:`ET_FRAC_W];

  always @(posedge clk_i) begin
    if (rst_i) begin
      rtc_s1_ff <= 1'b0;
      rtc_s2_ff <= 1'b0;
      rtc_s3_ff <= 1'b0;
    end else begin
      rtc_s1_ff <= rtc_clk_i;
      rtc_s2_ff <= rtc_s1_ff;
      rtc_s3_ff <= rtc_s2_ff;
    end
  end
  assign rtc_rise = rtc_s2_ff & ~rtc_s3_ff;

  // Offload sequencing and counter next values
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_slow  = slow_ff;
    case (state_ff)
      ST_FAST: begin
        if (cnt_en_ff && tick_fast_i) begin
          nxt_cnt = cnt_ff + 64'h0000_0000_0000_0001;
        end
        // Software may load the count only while stopped
        if (wr_go && !tpage && ofs == `ET_OFS_CNT_LO && !cnt_en_ff) begin
          nxt_cnt[31:0] = merge(cnt_ff[31:0], dat_i, bmask);
        end
        if (wr_go && !tpage && ofs == `ET_OFS_CNT_HI && !cnt_en_ff) begin
          nxt_cnt[63:32] = merge(cnt_ff[63:32], dat_i, bmask);
        end
        if (rtc_rise && offload_req_i && !any_active && cnt_en_ff) begin
          nxt_slow  = {cnt_ff, slow_ff[`ET_FRAC_W-1:0]};
          nxt_state = ST_PARK;
        end
      end
      ST_PARK: begin
        if (rtc_rise) begin
          nxt_slow = slow_ff + cal_ext;
          if (!offload_req_i) begin
            // Early exit: add calibration and leave on the slow edge after entry
            nxt_cnt   = nxt_slow[`ET_SLOW_W-1:`ET_FRAC_W];
            nxt_state = ST_FAST;
          end else begin
            nxt_state = ST_SLOW;
          end
        end
      end
      ST_SLOW: begin
        if (rtc_rise) begin
          if (!offload_req_i) begin
            nxt_cnt   = slow_ff[`ET_SLOW_W-1:`ET_FRAC_W];
            nxt_state = ST_FAST;
          end else begin
            nxt_slow = slow_ff + cal_ext;
          end
        end
      end
      default: begin
        nxt_state = ST_FAST;
      end
    endcase
  end

  // full 82-bit sum keeps the 18 fraction bits
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff     <= ST_FAST;
      cnt_ff       <= `ET_RST_CNT;
      slow_ff      <= {`ET_SLOW_W{1'b0}};
      view_prev_ff <= `ET_RST_CNT;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      slow_ff      <= nxt_slow;
      view_prev_ff <= view;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `ET_NUM_TMR; gi = gi + 1) begin : g_tmr
      wire [3:0] wr_sel;
      assign wr_sel[0] = wr_go & tpage & (tsel == gi) & (treg == `ET_TMR_CMP_LO);
      assign wr_sel[1] = wr_go & tpage & (tsel == gi) & (treg == `ET_TMR_CMP_HI);
      assign wr_sel[2] = wr_go & tpage & (tsel == gi) & (treg == `ET_TMR_PER_LO);
      assign wr_sel[3] = wr_go & tpage & (tsel == gi) & (treg == `ET_TMR_PER_HI);
      timer_cmp #(
        .HAS_PERIOD (`ET_PERIODIC_CAP >> gi & 1)
      ) u_cmp (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cnt_i      (view),
        .step_i     (view != view_prev_ff),
        .en_i       (tmr_en_ff[gi]),
        .periodic_i (tmr_per_ff[gi]),
        .wdat_i     (dat_i),
        .wr_i       (wr_sel),
        .cmp_o      (cmp_w[gi]),
        .per_o      (per_w[gi]),
        .fire_o     (fire[gi])
      );
    end
  endgenerate

  // Control registers, sticky status with set winning over clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_en_ff  <= `ET_RST_CFG;
      tmr_en_ff  <= 8'h00;
      tmr_per_ff <= 8'h00;
      sts_ff     <= 8'h00;
      mask_ff    <= `ET_RST_MASK;
    end else begin
      if (wr_go && !tpage && ofs == `ET_OFS_CFG && sel_i[0]) begin
        cnt_en_ff <= dat_i[`ET_CFG_CNT_EN];
      end
      if (wr_go && !tpage && ofs == `ET_OFS_INT_MASK && sel_i[0]) begin
        mask_ff <= dat_i[7:0];
      end
      if (wr_go && tpage && treg == `ET_TMR_CFG && sel_i[0]) begin
        tmr_en_ff[tsel]  <= dat_i[`ET_TCFG_EN];
        tmr_per_ff[tsel] <= dat_i[`ET_TCFG_PERIODIC] & per_cap[tsel];
      end
      if (wr_go && !tpage && ofs == `ET_OFS_INT_STS && sel_i[0]) begin
        sts_ff <= (sts_ff & ~dat_i[7:0]) | fire;
      end else begin
        sts_ff <= sts_ff | fire;
      end
    end
  end

  // one interrupt per timer plus a combined line
  always @(posedge clk_i) begin
    if (rst_i) begin
      timer_irq_o <= 8'h00;
      irq_o       <= 1'b0;
    end else begin
      timer_irq_o <= sts_ff & mask_ff;
      irq_o       <= |(sts_ff & mask_ff);
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    rd_val = 32'h0000_0000;
    if (tpage) begin
      case (treg)
        `ET_TMR_CFG: begin
          rd_val = {30'h0000_0000, tmr_per_ff[tsel], tmr_en_ff[tsel]};
        end
        `ET_TMR_CMP_LO: rd_val = cmp_w[tsel][31:0];
        `ET_TMR_CMP_HI: rd_val = cmp_w[tsel][63:32];
        `ET_TMR_PER_LO: rd_val = per_w[tsel][31:0];
        `ET_TMR_PER_HI: rd_val = per_w[tsel][63:32];
        default:        rd_val = 32'h0000_0000;
      endcase
    end else begin
      case (ofs)
        `ET_OFS_CFG:      rd_val = {31'h0000_0000, cnt_en_ff};
        `ET_OFS_CNT_LO:   rd_val = view[31:0];
        `ET_OFS_CNT_HI:   rd_val = view[63:32];
        `ET_OFS_INT_STS:  rd_val = {24'h00_0000, sts_ff};
        `ET_OFS_INT_MASK: rd_val = {24'h00_0000, mask_ff};
        `ET_OFS_OFFLOAD: begin
          rd_val = {29'h0000_0000, offload_req_i, any_active, slow_mode_o};
        end
        `ET_OFS_CALIB:    rd_val = {4'h0, calib_i};
        default:          rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Wishbone answer one cycle after the request, dropped the next cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req_hit & ~ack_o;
      if (req_hit && !ack_o && !we_i) begin
        dat_o <= rd_val;
      end
    end
  end

endmodule

// ===== verification/event_timer_sva.sv
`timescale 1ns/100ps
// Port-level checks on the event timer
module event_timer_sva (
  input logic        clk_i,
  input logic        rst_i,
  input logic [31:0] adr_i,
  input logic        cyc_i,
  input logic        stb_i,
  input logic        we_i,
  input logic        ack_o,
  input logic [19:0] decode_base_i,
  input logic        rtc_clk_i,
  input logic        offload_req_i,
  input logic        slow_mode_o,
  input logic [7:0]  timer_irq_o,
  input logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_take: assert property (cyc_i && stb_i && adr_i[31:12] == decode_base_i && !ack_o
    |=> ack_o) else $error("request in window not acked");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than a cycle");
  a_ack_outside: assert property (adr_i[31:12] != decode_base_i |=> !ack_o)
    else $error("ack outside window");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_irq_or: assert property (irq_o == |timer_irq_o) else $error("irq not OR of timers");
  a_irq_clear: assert property ($fell(irq_o) |-> $past(cyc_i && stb_i && we_i, 2))
    else $error("irq dropped without write");
  a_slow_entry: assert property ($rose(slow_mode_o) |-> $past(offload_req_i))
    else $error("slow mode without request");
  a_slow_exit: assert property ($fell(slow_mode_o) |-> !$past(offload_req_i))
    else $error("slow mode left under request");
  a_slow_edge: assert property ($changed(slow_mode_o) |-> $past(rtc_clk_i, 3))
    else $error("mode switch away from slow edge");
endmodule

bind event_timer event_timer_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .decode_base_i(decode_base_i),
  .rtc_clk_i(rtc_clk_i), .offload_req_i(offload_req_i), .slow_mode_o(slow_mode_o),
  .timer_irq_o(timer_irq_o), .irq_o(irq_o));

// ===== verification/power_ctl_model.sv
`timescale 1ns/100ps
// Crystal strobe, slow clock and power controller stand-in
module power_ctl_model #(
  parameter int          RTC_HALF = 40,
  parameter logic [27:0] CAL      = 28'h00C_0000
) (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic        want_i,
  input  logic        slow_mode_i,
  output logic        tick_o,
  output logic        rtc_o,
  output logic        req_o,
  output logic [27:0] calib_o
);
  int div_ff;
  int ph_ff;

  assign calib_o = CAL;

  // Slow clock shortened so a run stays brief
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 0;
      ph_ff <= 0;
      tick_o <= 1'b0;
      rtc_o <= 1'b0;
      req_o <= 1'b0;
    end else begin
      div_ff <= (div_ff + 1) % 4;
      ph_ff <= (ph_ff + 1) % (2 * RTC_HALF);
      rtc_o <= ph_ff < RTC_HALF;
      tick_o <= div_ff == 0 && !slow_mode_i;
      // held level, no wake pending here
      req_o <= want_i;
    end
  end
endmodule

// ===== verification/event_timer_bench.sv
`timescale 1ns/100ps
`include "event_timer_defines.vh"
module event_timer_bench;
  localparam logic [19:0] BASE = 20'h4_0000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        we_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic [3:0]  sel_i = 4'h0;
  logic        want = 1'b0;
  logic [31:0] adr_i = 32'h0000_0000;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o, q, a, b;
  logic        ack_o, tick, rtc, req, slow_mode_o, irq_o;
  logic [27:0] calib;
  logic [7:0]  timer_irq_o;
  int          n_fail = 0;
  int          num_checks = 0;

  event_timer dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .decode_base_i(BASE), .tick_fast_i(tick), .rtc_clk_i(rtc), .offload_req_i(req),
    .calib_i(calib), .slow_mode_o(slow_mode_o), .timer_irq_o(timer_irq_o), .irq_o(irq_o));
  power_ctl_model pc (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .slow_mode_i(slow_mode_o),
    .tick_o(tick), .rtc_o(rtc), .req_o(req), .calib_o(calib));

  // 100 MHz clock
  initial forever #5 clk_i = ~clk_i;

  task wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  // One classic cycle; waits on ack, never on a count
  task wb(input logic w, input logic [11:0] o, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hF;
    adr_i <= {BASE, o};
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  function logic [11:0] ta(input int n, input int o);
    ta = {`ET_TMR_PAGE, 3'(n), 3'(o), 2'b00};
  endfunction

  task wait_mode(input logic v);
    int t;
    t = 0;
    while (slow_mode_o !== v && t < 400) begin
      @(posedge clk_i);
      t++;
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `ET_OFS_CFG, 0);
    chk(q, 0);
    wb(0, ta(1, 1), 0);
    chk(q, 32'hFFFF_FFFF);
    wb(0, 12'h020, 0);
    chk(q, 0);
    wb(0, `ET_OFS_CALIB, 0);
    chk(q, 32'h000C_0000);
    $display("test reset done");
    wb(1, `ET_OFS_CFG, 1);
    repeat (400) @(posedge clk_i);
    wb(1, `ET_OFS_CFG, 0);
    wb(0, `ET_OFS_CNT_LO, 0);
    chk(q >= 100 && q <= 102, 1);
    wb(1, `ET_OFS_CNT_LO, 32'hFFFF_FFF8);
    wb(1, `ET_OFS_CNT_HI, 32'hFFFF_FFFF);
    wb(1, `ET_OFS_CFG, 1);
    repeat (100) @(posedge clk_i);
    wb(0, `ET_OFS_CNT_HI, 0);
    chk(q, 0);
    wb(0, `ET_OFS_CNT_LO, 0);
    a = q;
    // Space the reads past one tick period
    repeat (4) @(posedge clk_i);
    wb(0, `ET_OFS_CNT_LO, 0);
    chk(q > a, 1);
    $display("test count done");
    wb(1, `ET_OFS_CFG, 0);
    wb(1, `ET_OFS_CNT_LO, 0);
    wb(1, `ET_OFS_CNT_HI, 0);
    wb(1, `ET_OFS_INT_MASK, 32'h0000_00FF);
    for (int n = 0; n < 8; n++) begin
      wb(1, ta(n, 2), 0);
      wb(1, ta(n, 1), 8 * (n + 1));
      wb(1, ta(n, 0), 3);
    end
    wb(1, ta(0, 3), 16);
    wb(1, `ET_OFS_CFG, 1);
    repeat (400) @(posedge clk_i);
    wb(0, `ET_OFS_INT_STS, 0);
    chk(q, 32'h0000_00FF);
    wb(0, ta(1, 0), 0);
    chk(q, 1);
    wb(0, ta(0, 0), 0);
    chk(q, 3);
    wb(1, `ET_OFS_INT_STS, 32'h0000_00FE);
    wb(0, `ET_OFS_INT_STS, 0);
    chk(q, 1);
    wb(1, `ET_OFS_INT_STS, 1);
    repeat (100) @(posedge clk_i);
    wb(0, `ET_OFS_INT_STS, 0);
    chk(q, 1);
    wb(0, ta(0, 1), 0);
    chk((q - 8) % 16 == 0 && q > 8, 1);
    repeat (3) @(posedge clk_i);
    chk(timer_irq_o, 8'h01);
    chk(irq_o, 1);
    wb(1, `ET_OFS_INT_MASK, 0);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 0);
    $display("test timers done");
    want <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk(slow_mode_o, 0);
    for (int n = 0; n < 8; n++) wb(1, ta(n, 0), 0);
    wait_mode(1);
    chk(slow_mode_o, 1);
    wb(0, `ET_OFS_OFFLOAD, 0);
    chk(q, 32'h0000_0005);
    wb(0, `ET_OFS_CNT_LO, 0);
    a = q;
    repeat (80) @(posedge clk_i);
    wb(0, `ET_OFS_CNT_LO, 0);
    chk(q - a, 3);
    want <= 1'b0;
    wait_mode(0);
    chk(slow_mode_o, 0);
    wb(0, `ET_OFS_CNT_LO, 0);
    b = q;
    chk(b >= a + 3, 1);
    repeat (20) @(posedge clk_i);
    wb(0, `ET_OFS_CNT_LO, 0);
    chk(q > b, 1);
    $display("test offload done");
    wrap_up;
  end

  // Watchdog well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    wrap_up;
  end
endmodule
